// File: inc/l2rq_pkg.sv
////////////////////////////////////////////////////////////////////////////////
package l2rq_pkg;

    // event numbers understood by the qualifier
    localparam logic [7:0] L2RQ_EVT_REFS  = 8'h24;  // l2_all_references
    localparam logic [7:0] L2RQ_EVT_DATA  = 8'h26;  // demand and prefetch data loads
    localparam logic [7:0] L2RQ_EVT_WRITE = 8'h27;  // store and locked ownership

    // unit-mask values with a meaning of their own
    localparam logic [7:0] L2RQ_UM_ALL      = 8'hFF;  // every request of the event
    localparam logic [7:0] L2RQ_UM_NONE     = 8'h00;  // selects nothing
    localparam logic [7:0] L2RQ_UM_LOW_ANY  = 8'h0F;  // demand / store, any state
    localparam logic [7:0] L2RQ_UM_HIGH_ANY = 8'hF0;  // prefetch / locked, any state
    localparam logic [7:0] L2RQ_UM_LOW_HIT  = 8'h0E;  // store ownership hit
    localparam logic [7:0] L2RQ_UM_HIGH_HIT = 8'hE0;  // locked ownership hit

    // field layout of the unit mask: two four-bit state nibbles
    localparam int L2RQ_NIB_W    = 4;  // one bit per line state
    localparam int L2RQ_LOW_POS  = 0;  // demand load / store ownership nibble
    localparam int L2RQ_HIGH_POS = 4;  // prefetch load / locked ownership nibble
    localparam int L2RQ_GROUPS   = 4;  // request groups with a state nibble

    // reset values of the output flops
    localparam logic L2RQ_INC_RST = 1'b0;
    localparam logic L2RQ_DEF_RST = 1'b0;

    // kind of request reported by the cache pipeline
    typedef enum logic [2:0] {
        L2RQ_K_IFETCH,      // code fetch or code prefetch
        L2RQ_K_L1D_MISS,    // first-level data demand miss
        L2RQ_K_L1D_PF,      // first-level data prefetch
        L2RQ_K_PF_READ,     // second-level prefetch read
        L2RQ_K_PF_OWN,      // second-level prefetch read_for_ownership
        L2RQ_K_STORE_OWN,   // demand store read_for_ownership
        L2RQ_K_LOCK_OWN,    // locked read_for_ownership
        L2RQ_K_OTHER        // any other second-level request
    } l2rq_kind_t;

    // coherency state of the addressed line, bit index in a nibble
    typedef enum logic [1:0] {
        L2RQ_S_INVALID,
        L2RQ_S_SHARED,
        L2RQ_S_EXCLUSIVE,
        L2RQ_S_MODIFIED
    } l2rq_line_t;

endpackage : l2rq_pkg

// File: rtl/l2rq_state_match.sv
////////////////////////////////////////////////////////////////////////////////
// one request group: picks the line state out of a four-bit state nibble
module l2rq_state_match
    import l2rq_pkg::*;
(
    // group selection
    input  wire logic                            group_en_i,
    input  wire logic [l2rq_pkg::L2RQ_NIB_W-1:0] state_mask_i,
    // request line state
    input  wire l2rq_pkg::l2rq_line_t            line_state_i,
    // result
    output logic                                 hit_o
);
    import l2rq_pkg::*;

    logic [L2RQ_NIB_W-1:0] per_state;  // one term per coherency state

    ////////////////////////////////////////////////////////////////////////////
    // one selected mask bit against the decoded state
    for (genvar s = 0; s < L2RQ_NIB_W; s++) begin : g_state
        assign per_state[s] = state_mask_i[s] && (line_state_i == l2rq_line_t'(s));
    end

    // any selected state is enough
    assign hit_o = group_en_i && (|per_state);

endmodule : l2rq_state_match

// File: rtl/l2rq_qualifier.sv
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module l2rq_qualifier
    import l2rq_pkg::*;
(
    // clock and reset
    input  wire logic                 CLK_I,
    input  wire logic                 RST_N_I,
    // event selection from the counter control
    input  wire logic [7:0]           EVENT_SEL_I,
    input  wire logic [7:0]           UNIT_MASK_I,
    // request report from the cache pipeline
    input  wire logic                 REQ_VALID_I,
    input  wire l2rq_pkg::l2rq_kind_t REQ_KIND_I,
    input  wire l2rq_pkg::l2rq_line_t LINE_STATE_I,
    // to the counter
    output logic                      COUNT_INC_O,
    output logic                      SEL_DEFINED_O
);
    import l2rq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic                   is_demand_ld;        // demand data load class
    logic                   is_prefetch_ld;      // prefetch data load class
    l2rq_line_t             eff_state;           // state as seen for counting
    logic [L2RQ_GROUPS-1:0] group_en;            // group enabled by event and kind
    logic [L2RQ_GROUPS-1:0] group_hit;           // group matched a selected state
    logic                   refs_sel;            // all-references selection
    logic                   defined_sel;         // selection is a known combination
    logic                   count_inc_reg;       // registered increment
    logic                   count_inc_next;      // next increment
    logic                   sel_defined_reg;     // registered selection status
    logic                   sel_defined_next;    // next selection status

    ////////////////////////////////////////////////////////////////////////////
    // request classification
    always_comb begin
        // both first-level miss and first-level prefetch are demand loads
        is_demand_ld   = (REQ_KIND_I == L2RQ_K_L1D_MISS) ||
                         (REQ_KIND_I == L2RQ_K_L1D_PF);
        // second-level prefetch reads and prefetch ownership are prefetch loads
        is_prefetch_ld = (REQ_KIND_I == L2RQ_K_PF_READ) ||
                         (REQ_KIND_I == L2RQ_K_PF_OWN);
        // a prefetch ownership on a shared line must fetch again: a miss
        if ((REQ_KIND_I == L2RQ_K_PF_OWN) && (LINE_STATE_I == L2RQ_S_SHARED)) begin
            eff_state = L2RQ_S_INVALID;
        end else begin
            eff_state = LINE_STATE_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // group enables: event number picks the pair, kind picks the group
    always_comb begin
        group_en[0] = (EVENT_SEL_I == L2RQ_EVT_DATA)  && is_demand_ld;
        group_en[1] = (EVENT_SEL_I == L2RQ_EVT_DATA)  && is_prefetch_ld;
        // only demand store ownership; prefetch ownership never lands here
        group_en[2] = (EVENT_SEL_I == L2RQ_EVT_WRITE) &&
                      (REQ_KIND_I == L2RQ_K_STORE_OWN);
        group_en[3] = (EVENT_SEL_I == L2RQ_EVT_WRITE) &&
                      (REQ_KIND_I == L2RQ_K_LOCK_OWN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-group state match, low nibble for even groups, high for odd
    for (genvar g = 0; g < L2RQ_GROUPS; g++) begin : g_group
        localparam int POS = (g % 2 == 0) ? L2RQ_LOW_POS : L2RQ_HIGH_POS;
        l2rq_state_match u_match (
            .group_en_i   (group_en[g]),
            .state_mask_i (UNIT_MASK_I[POS +: L2RQ_NIB_W]),
            .line_state_i (eff_state),
            .hit_o        (group_hit[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // selection decode
    always_comb begin
        // every request, whatever its kind
        refs_sel    = (EVENT_SEL_I == L2RQ_EVT_REFS) && (UNIT_MASK_I == L2RQ_UM_ALL);
        // anything else leaves the counter still
        defined_sel = refs_sel ||
                      (((EVENT_SEL_I == L2RQ_EVT_DATA) || (EVENT_SEL_I == L2RQ_EVT_WRITE))
                       && (UNIT_MASK_I != L2RQ_UM_NONE));
    end

    ////////////////////////////////////////////////////////////////////////////
    // next output values
    always_comb begin
        sel_defined_next = defined_sel;
        if (!REQ_VALID_I) begin
            // no request, no increment
            count_inc_next = 1'b0;
        end else if (refs_sel) begin
            count_inc_next = 1'b1;
        end else begin
            // any selected group and state bit counts once
            count_inc_next = defined_sel && (|group_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            count_inc_reg   <= L2RQ_INC_RST;
            sel_defined_reg <= L2RQ_DEF_RST;
        end else begin
            count_inc_reg   <= count_inc_next;
            sel_defined_reg <= sel_defined_next;
        end
    end

    assign COUNT_INC_O   = count_inc_reg;
    assign SEL_DEFINED_O = sel_defined_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // request seen with the selection of the same cycle
    sequence s_req(logic [7:0] ev, logic [7:0] um);
        REQ_VALID_I && EVENT_SEL_I == ev && UNIT_MASK_I == um;
    endsequence

    a_all_refs_count: assert property (
        s_req(L2RQ_EVT_REFS, L2RQ_UM_ALL) |=> COUNT_INC_O)
        else $error("reference not counted");
    a_demand_state_pick: assert property (
        s_req(L2RQ_EVT_DATA, 8'h01) and (REQ_KIND_I == L2RQ_K_L1D_MISS)
        |=> COUNT_INC_O == $past(LINE_STATE_I == L2RQ_S_INVALID))
        else $error("demand state select wrong");
    a_l1d_pf_demand: assert property (
        s_req(L2RQ_EVT_DATA, L2RQ_UM_LOW_ANY) and (REQ_KIND_I == L2RQ_K_L1D_PF)
        |=> COUNT_INC_O)
        else $error("first-level prefetch not a demand load");
    a_demand_any_state: assert property (
        s_req(L2RQ_EVT_DATA, L2RQ_UM_LOW_ANY)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_L1D_MISS
                                 || REQ_KIND_I == L2RQ_K_L1D_PF))
        else $error("demand any-state count wrong");
    a_demand_mask_or: assert property (
        s_req(L2RQ_EVT_DATA, 8'h03) and (REQ_KIND_I == L2RQ_K_L1D_MISS)
        |=> COUNT_INC_O == $past(LINE_STATE_I == L2RQ_S_INVALID
                                 || LINE_STATE_I == L2RQ_S_SHARED))
        else $error("mask bits not combined");
    a_pf_modified_pick: assert property (
        s_req(L2RQ_EVT_DATA, 8'h80) and (REQ_KIND_I == L2RQ_K_PF_READ)
        |=> COUNT_INC_O == $past(LINE_STATE_I == L2RQ_S_MODIFIED))
        else $error("prefetch state select wrong");
    a_pf_own_shared: assert property (
        REQ_VALID_I && EVENT_SEL_I == L2RQ_EVT_DATA && UNIT_MASK_I == 8'h20
        && LINE_STATE_I == L2RQ_S_SHARED
        && (REQ_KIND_I == L2RQ_K_PF_READ || REQ_KIND_I == L2RQ_K_PF_OWN)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_PF_READ))
        else $error("shared prefetch hit or miss wrong");
    a_pf_any_state: assert property (
        s_req(L2RQ_EVT_DATA, L2RQ_UM_HIGH_ANY)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_PF_READ
                                 || REQ_KIND_I == L2RQ_K_PF_OWN))
        else $error("prefetch any-state count wrong");
    a_data_any: assert property (
        s_req(L2RQ_EVT_DATA, L2RQ_UM_ALL)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_L1D_MISS
                                 || REQ_KIND_I == L2RQ_K_L1D_PF
                                 || REQ_KIND_I == L2RQ_K_PF_READ
                                 || REQ_KIND_I == L2RQ_K_PF_OWN))
        else $error("data any count wrong");
    a_store_state_pick: assert property (
        s_req(L2RQ_EVT_WRITE, 8'h08) and (REQ_KIND_I == L2RQ_K_STORE_OWN)
        |=> COUNT_INC_O == $past(LINE_STATE_I == L2RQ_S_MODIFIED))
        else $error("store state select wrong");
    a_store_hit_only: assert property (
        s_req(L2RQ_EVT_WRITE, L2RQ_UM_LOW_HIT) and (REQ_KIND_I == L2RQ_K_STORE_OWN)
        |=> COUNT_INC_O == $past(LINE_STATE_I != L2RQ_S_INVALID))
        else $error("store hit count wrong");
    a_store_any_state: assert property (
        s_req(L2RQ_EVT_WRITE, L2RQ_UM_LOW_ANY)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_STORE_OWN))
        else $error("store any-state count wrong");
    a_no_pf_ownership: assert property (
        REQ_VALID_I && EVENT_SEL_I == L2RQ_EVT_WRITE && REQ_KIND_I == L2RQ_K_PF_OWN
        |=> !COUNT_INC_O)
        else $error("prefetch ownership counted as store");
    a_lock_hit_only: assert property (
        s_req(L2RQ_EVT_WRITE, L2RQ_UM_HIGH_HIT) and (REQ_KIND_I == L2RQ_K_LOCK_OWN)
        |=> COUNT_INC_O == $past(LINE_STATE_I != L2RQ_S_INVALID))
        else $error("locked hit count wrong");
    a_lock_any_state: assert property (
        s_req(L2RQ_EVT_WRITE, L2RQ_UM_HIGH_ANY)
        |=> COUNT_INC_O == $past(REQ_KIND_I == L2RQ_K_LOCK_OWN))
        else $error("locked any-state count wrong");
    a_undefined_quiet: assert property (
        !(EVENT_SEL_I == L2RQ_EVT_REFS && UNIT_MASK_I == L2RQ_UM_ALL)
        && !((EVENT_SEL_I == L2RQ_EVT_DATA || EVENT_SEL_I == L2RQ_EVT_WRITE)
             && UNIT_MASK_I != L2RQ_UM_NONE)
        |=> !COUNT_INC_O && !SEL_DEFINED_O)
        else $error("undefined selection incremented");
    a_idle_quiet: assert property (
        !REQ_VALID_I |=> !COUNT_INC_O)
        else $error("increment without request");

    c_refs_burst: cover property (s_req(L2RQ_EVT_REFS, L2RQ_UM_ALL) [*3]);
    c_pf_own_miss: cover property (s_req(L2RQ_EVT_DATA, 8'h10)
        and (REQ_KIND_I == L2RQ_K_PF_OWN) and (LINE_STATE_I == L2RQ_S_SHARED));
    c_lock_count: cover property (COUNT_INC_O && $past(REQ_KIND_I == L2RQ_K_LOCK_OWN));

endmodule : l2rq_qualifier

// File: tb/l2rq_req_model.sv
////////////////////////////////////////////////////////////////////////////////
// stand-in for the cache request pipeline, one report per clock
module l2rq_req_model
    import l2rq_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // request report
    output logic       valid_o,
    output l2rq_kind_t kind_o,
    output l2rq_line_t state_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle report until the bench asks for one
    initial begin
        valid_o = 1'b0;
        kind_o  = L2RQ_K_OTHER;
        state_o = L2RQ_S_INVALID;
    end

    // present one report; caller sits just after a rising edge
    task automatic put(input logic v, input l2rq_kind_t k, input l2rq_line_t s);
        valid_o = v;
        // an idle slot still wiggles kind and state so stale values never count
        kind_o  = v ? k : l2rq_kind_t'($urandom_range(7));
        state_o = v ? s : l2rq_line_t'($urandom_range(3));
    endtask : put
endmodule : l2rq_req_model

// File: tb/tb_l2_request_event_qualifier.sv
////////////////////////////////////////////////////////////////////////////////
module tb_l2_request_event_qualifier;
    import l2rq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;      // core clock
    logic       rst_n = 1'b0;    // synchronous reset
    logic [7:0] ev_sel = 8'h00;  // event number
    logic [7:0] umask = 8'h00;   // unit mask
    logic       req_v;           // request valid from model
    l2rq_kind_t req_k;           // request kind from model
    l2rq_line_t req_s;           // line state from model
    logic       cnt_inc;         // increment pulse
    logic       sel_def;         // defined selection flag
    logic       exp_c = 1'b0;    // expected increment next cycle
    logic       exp_d = 1'b0;    // expected defined flag next cycle
    logic [7:0] last_ev = 8'h00; // event of the pending expectation
    int         bad_count = 0;
    int         checks = 0;
    logic [7:0] evs [5] = '{8'h24, 8'h26, 8'h27, 8'h25, 8'h00};
    logic [7:0] ums [15] = '{8'hFF, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h10, 8'h20,
                             8'h40, 8'h80, 8'hF0, 8'h0E, 8'hE0, 8'h00, 8'h03};

    // 50 MHz clock
    always #10 clk = ~clk;

    l2rq_req_model req (.clk_i(clk), .valid_o(req_v), .kind_o(req_k), .state_o(req_s));

    l2rq_qualifier DUT (
        .CLK_I        (clk),
        .RST_N_I      (rst_n),
        .EVENT_SEL_I  (ev_sel),
        .UNIT_MASK_I  (umask),
        .REQ_VALID_I  (req_v),
        .REQ_KIND_I   (req_k),
        .LINE_STATE_I (req_s),
        .COUNT_INC_O  (cnt_inc),
        .SEL_DEFINED_O(sel_def)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reference: does one request count under this selection
    function automatic logic ref_inc(input logic [7:0] ev, input logic [7:0] um,
            input logic v, input l2rq_kind_t k, input l2rq_line_t s);
        int i;
        i = int'(s);
        ref_inc = 1'b0;
        if (v !== 1'b1) return 1'b0;
        if (ev == L2RQ_EVT_REFS) ref_inc = (um == L2RQ_UM_ALL);
        else if (ev == L2RQ_EVT_DATA) begin
            if (k == L2RQ_K_L1D_MISS || k == L2RQ_K_L1D_PF) ref_inc = um[i];
            else if (k == L2RQ_K_PF_READ) ref_inc = um[4+i];
            // ownership prefetch on a shared line is a miss
            else if (k == L2RQ_K_PF_OWN) ref_inc = (i == 1) ? um[4] : um[4+i];
        end else if (ev == L2RQ_EVT_WRITE) begin
            if (k == L2RQ_K_STORE_OWN) ref_inc = um[i];
            else if (k == L2RQ_K_LOCK_OWN) ref_inc = um[4+i];
        end
    endfunction : ref_inc

    // reference: is the selection a defined one
    function automatic logic ref_def(input logic [7:0] ev, input logic [7:0] um);
        ref_def = (ev == L2RQ_EVT_REFS && um == L2RQ_UM_ALL) ||
                  ((ev == L2RQ_EVT_DATA || ev == L2RQ_EVT_WRITE) && um != 8'h00);
    endfunction : ref_def

    ////////////////////////////////////////////////////////////////////////////
    // compare one value
    task automatic check(input logic seen, input logic want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: seen %b expected %b ev %h", $time, seen, want, last_ev);
        end
    endtask : check

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // one cycle: check previous answer, then present the next request
    task automatic step(input logic [7:0] ev, input logic [7:0] um, input logic v,
            input l2rq_kind_t k, input l2rq_line_t s);
        @(posedge clk);
        #1;
        case (last_ev)
            L2RQ_EVT_REFS: check(cnt_inc, exp_c);
            L2RQ_EVT_DATA: check(cnt_inc, exp_c);
            L2RQ_EVT_WRITE: check(cnt_inc, exp_c);
            default: check(cnt_inc, exp_c);
        endcase
        check(sel_def, exp_d);
        ev_sel  = ev;
        umask   = um;
        req.put(v, k, s);
        exp_c   = ref_inc(ev, um, v, k, s);
        exp_d   = ref_def(ev, um);
        last_ev = ev;
    endtask : step

    // reset held two edges with idle inputs, outputs stay low
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2)
            step(8'h00, 8'h00, 1'b0, L2RQ_K_OTHER, L2RQ_S_INVALID);
        rst_n = 1'b1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #(20 * 8000);
        bad_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        void'($urandom(32'hd48511be));
        do_reset();
        // every table selection against every kind and state, back to back
        foreach (evs[e])
            foreach (ums[m])
                for (int k = 0; k < 8; k++)
                    for (int s = 0; s < 4; s++)
                        step(evs[e], ums[m], 1'b1, l2rq_kind_t'(k), l2rq_line_t'(s));
        // last table answer is checked before reset clears it
        step(8'h00, 8'h00, 1'b0, L2RQ_K_OTHER, L2RQ_S_INVALID);
        do_reset();
        // random traffic and random selections
        repeat (3000)
            step(($urandom_range(3) == 0) ? 8'($urandom) : evs[$urandom_range(2)],
                 ($urandom_range(1) == 0) ? ums[$urandom_range(14)] : 8'($urandom),
                 1'($urandom), l2rq_kind_t'($urandom_range(7)),
                 l2rq_line_t'($urandom_range(3)));
        step(8'h00, 8'h00, 1'b0, L2RQ_K_OTHER, L2RQ_S_INVALID);
        print_verdict();
    end
endmodule : tb_l2_request_event_qualifier
